// ---- hdl/ddp_core.sv ----
// dual converter control: serial command link, power-down, clear, wishbone
// assumes serial_clk is the host's clock, idle outside frames, and
// frame_sync_n/serial_in change on its rising edge
`timescale 1ns/1ps
`default_nettype none

module ddp_core
  import ddp_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ddp_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link from host
  input wire logic serial_clk,
  input wire logic frame_sync_n,
  input wire logic serial_in,
  // asynchronous clear pin
  input wire logic async_clear_n,
  // converter control outputs
  output logic [ddp_pkg::CODE_W-1:0] level_a,
  output logic [ddp_pkg::CODE_W-1:0] level_b,
  output logic pd_a,
  output logic pd_b,
  output ddp_pkg::ddp_term_t term_a,
  output ddp_pkg::ddp_term_t term_b,
  output logic clear_active
);
  import ddp_pkg::*;

  // link domain: bit counter and shifter, cleared while the strobe is high
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [WORD_W-2:0] shift;
  } ddp_link_t;

  // link domain: completed word and its event toggle
  typedef struct packed {
    logic [WORD_W-1:0] hold;
    logic tgl;
  } ddp_cap_t;

  // system domain, bus side; reset only by rst
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic link_en;
    logic [2:0] tgl_s;
    logic [2:0] fs_s;
    logic [FRM_W-1:0] n_exec;
    logic [FRM_W-1:0] n_ign;
  } ddp_bus_t;

  // system domain, converter state; reset by rst or clear
  typedef struct packed {
    logic [CODE_W-1:0] tmp_a;
    logic [CODE_W-1:0] tmp_b;
    logic [CODE_W-1:0] lvl_a;
    logic [CODE_W-1:0] lvl_b;
    logic pd_a;
    logic pd_b;
    ddp_term_t term_a;
    ddp_term_t term_b;
    logic pend;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] last;
  } ddp_conv_t;

  ddp_link_t link_reg;
  ddp_link_t link_next;
  ddp_cap_t cap_reg;
  ddp_cap_t cap_next;
  ddp_bus_t bus_reg;
  ddp_bus_t bus_next;
  ddp_conv_t conv_reg;
  ddp_conv_t conv_next;

  logic link_arst;
  logic clr_arst;
  logic clr_q0_reg;
  logic clr_q1_reg;
  logic bus_req;
  logic sw_fire;
  logic fs_rise;
  logic tgl_chg;
  logic exec_ser;
  logic go;
  logic [WORD_W-1:0] cmd;

  // link logic
  // the strobe itself ends the frame: no serial clock edge follows it
  assign link_arst = rst | frame_sync_n;

  always_comb begin
    link_next = link_reg;
    if (link_reg.cnt != FRAME_BITS) begin
      link_next.shift = {link_reg.shift[WORD_W-3:0], serial_in};
      link_next.cnt = link_reg.cnt + 5'h01;
    end
  end

  always_ff @(negedge serial_clk or posedge link_arst) begin
    if (link_arst) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // only the first sixteen bits of a frame are kept
  always_comb begin
    cap_next = cap_reg;
    if (link_reg.cnt == LAST_BIT) begin
      cap_next.hold = {link_reg.shift, serial_in};
      cap_next.tgl = ~cap_reg.tgl;
    end
  end

  always_ff @(negedge serial_clk or posedge rst) begin
    if (rst) begin
      cap_reg <= '0;
    end else begin
      cap_reg <= cap_next;
    end
  end

  // clear: asserts at once, releases synchronously to clk_sys
  assign clr_arst = rst | ~async_clear_n;

  always_ff @(posedge clk_sys or posedge clr_arst) begin
    if (clr_arst) begin
      clr_q0_reg <= 1'b1;
      clr_q1_reg <= 1'b1;
    end else begin
      clr_q0_reg <= 1'b0;
      clr_q1_reg <= clr_q0_reg;
    end
  end

  // bus slave
  assign bus_req = wb_cyc_i & wb_stb_i & ~bus_reg.ack;
  assign sw_fire = bus_req & wb_we_i & (wb_adr_i == ADR_CMD) & (&wb_sel_i[1:0]);
  assign fs_rise = bus_reg.fs_s[1] & ~bus_reg.fs_s[2];
  assign tgl_chg = bus_reg.tgl_s[1] ^ bus_reg.tgl_s[2];
  assign exec_ser = fs_rise & conv_reg.pend;

  always_comb begin
    bus_next = bus_reg;
    bus_next.ack = bus_req;
    bus_next.fs_s = {bus_reg.fs_s[1:0], frame_sync_n};
    bus_next.tgl_s = {bus_reg.tgl_s[1:0], cap_reg.tgl};
    if (exec_ser) begin
      bus_next.n_exec = bus_reg.n_exec + 8'h01;
    end else if (fs_rise) begin
      bus_next.n_ign = bus_reg.n_ign + 8'h01;
    end
    if (bus_req & wb_we_i) begin
      if ((wb_adr_i == ADR_CTRL) && wb_sel_i[0]) begin
        bus_next.link_en = wb_dat_i[CTRL_LINK_EN];
      end
    end
    if (bus_req & ~wb_we_i) begin
      bus_next.rdata = RD_ZERO;
      if (wb_adr_i == ADR_CTRL) begin
        bus_next.rdata[CTRL_LINK_EN] = bus_reg.link_en;
      end else if (wb_adr_i == ADR_STATUS) begin
        bus_next.rdata[7:0] = {clr_q1_reg, conv_reg.pend,
                               conv_reg.term_b, conv_reg.term_a,
                               conv_reg.pd_b, conv_reg.pd_a};
      end else if (wb_adr_i == ADR_CODE_A) begin
        bus_next.rdata[CODE_W-1:0] = conv_reg.lvl_a ^ SIGN_FLIP;
        bus_next.rdata[TMP_LSB+CODE_W-1:TMP_LSB] = conv_reg.tmp_a;
      end else if (wb_adr_i == ADR_CODE_B) begin
        bus_next.rdata[CODE_W-1:0] = conv_reg.lvl_b ^ SIGN_FLIP;
        bus_next.rdata[TMP_LSB+CODE_W-1:TMP_LSB] = conv_reg.tmp_b;
      end else if (wb_adr_i == ADR_LAST) begin
        bus_next.rdata[WORD_W-1:0] = conv_reg.last;
      end else if (wb_adr_i == ADR_FRAMES) begin
        bus_next.rdata[FRM_W-1:0] = bus_reg.n_exec;
        bus_next.rdata[FRM_IGN_LSB+FRM_W-1:FRM_IGN_LSB] = bus_reg.n_ign;
      end else begin
        bus_next.rdata = RD_ZERO;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_reg.ack <= 1'b0;
      bus_reg.rdata <= RD_ZERO;
      bus_reg.link_en <= CTRL_RST[CTRL_LINK_EN];
      bus_reg.tgl_s <= '0;
      bus_reg.fs_s <= '1;
      bus_reg.n_exec <= '0;
      bus_reg.n_ign <= '0;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // command execution; a serial word wins over a software word
  assign go = exec_ser | sw_fire;
  assign cmd = exec_ser ? conv_reg.word : wb_dat_i[WORD_W-1:0];

  always_comb begin
    logic hit_a;
    logic hit_b;
    logic upd_a;
    logic upd_b;
    logic [CODE_W-1:0] data;
    ddp_term_t term;
    hit_a = 1'b0;
    hit_b = 1'b0;
    upd_a = 1'b0;
    upd_b = 1'b0;
    data = cmd[DATA_MSB:0];
    term = DDP_TERM_FLOAT;
    conv_next = conv_reg;
    // a new word arriving with the strobe rise is kept, not lost
    if (exec_ser) begin
      conv_next.pend = 1'b0;
    end
    if (tgl_chg & bus_reg.link_en) begin
      conv_next.pend = 1'b1;
      conv_next.word = cap_reg.hold;
    end
    if (go) begin
      conv_next.last = cmd;
      if (cmd[BIT_PD]) begin
        // bit 13 and data bits 9..0 are not looked at
        hit_a = cmd[BIT_SEL_HI:BIT_SEL_LO] != SEL_B;
        hit_b = cmd[BIT_SEL_HI:BIT_SEL_LO] != SEL_A;
        case (cmd[BIT_TERM_HI:BIT_TERM_LO])
          2'b01: term = DDP_TERM_1K;
          2'b10: term = DDP_TERM_100K;
          default: term = DDP_TERM_FLOAT;
        endcase
        if (hit_a) begin
          conv_next.pd_a = 1'b1;
          conv_next.term_a = term;
        end
        if (hit_b) begin
          conv_next.pd_b = 1'b1;
          conv_next.term_b = term;
        end
      end else begin
        case (cmd[BIT_SEL_HI:BIT_SEL_LO])
          SEL_BOTH0: begin
            if (cmd[BIT_CH]) begin
              conv_next.tmp_b = data;
            end else begin
              conv_next.tmp_a = data;
            end
          end
          SEL_A: begin
            if (cmd[BIT_CH]) begin
              conv_next.tmp_b = data;
              upd_b = 1'b1;
            end else begin
              conv_next.tmp_a = data;
              upd_a = 1'b1;
            end
          end
          SEL_B: begin
            upd_a = 1'b1;
            upd_b = 1'b1;
            if (cmd[BIT_CH]) begin
              conv_next.tmp_b = data;
            end else begin
              conv_next.tmp_a = data;
            end
          end
          default: begin
            upd_a = 1'b1;
            upd_b = 1'b1;
            if (!cmd[BIT_CH]) begin
              conv_next.tmp_a = data;
              conv_next.tmp_b = data;
            end
          end
        endcase
        // output level is the unsigned equivalent of the new code
        if (upd_a) begin
          conv_next.lvl_a = conv_next.tmp_a ^ SIGN_FLIP;
          conv_next.pd_a = 1'b0;
        end
        if (upd_b) begin
          conv_next.lvl_b = conv_next.tmp_b ^ SIGN_FLIP;
          conv_next.pd_b = 1'b0;
        end
      end
    end
  end

  // clear drops a pending word, not the link shifter: a frame completing after release still acts
  always_ff @(posedge clk_sys or posedge clr_q1_reg) begin
    if (clr_q1_reg) begin
      conv_reg.tmp_a <= CODE_RST;
      conv_reg.tmp_b <= CODE_RST;
      conv_reg.lvl_a <= LEVEL_RST;
      conv_reg.lvl_b <= LEVEL_RST;
      conv_reg.pd_a <= 1'b0;
      conv_reg.pd_b <= 1'b0;
      conv_reg.term_a <= DDP_TERM_FLOAT;
      conv_reg.term_b <= DDP_TERM_FLOAT;
      conv_reg.pend <= 1'b0;
      conv_reg.word <= '0;
      conv_reg.last <= '0;
    end else begin
      conv_reg <= conv_next;
    end
  end

  // outputs
  assign wb_dat_o = bus_reg.rdata;
  assign wb_ack_o = bus_reg.ack;
  assign level_a = conv_reg.lvl_a;
  assign level_b = conv_reg.lvl_b;
  assign pd_a = conv_reg.pd_a;
  assign pd_b = conv_reg.pd_b;
  assign term_a = conv_reg.term_a;
  assign term_b = conv_reg.term_b;
  assign clear_active = clr_q1_reg;

endmodule

`default_nettype wire

// ---- hdl/ddp_pkg.sv ----
// constants and types of the dual converter power-down and clear control
// shared by the control core; no logic here
package ddp_pkg;

  // serial command word
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;
  localparam int BIT_SEL_HI = 15;
  localparam int BIT_SEL_LO = 14;
  localparam int BIT_CH = 13;
  localparam int BIT_PD = 12;
  localparam int BIT_TERM_HI = 11;
  localparam int BIT_TERM_LO = 10;
  localparam int DATA_MSB = 11;

  // target select, bits 15..14
  localparam logic [1:0] SEL_BOTH0 = 2'h0;
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam logic [1:0] SEL_BOTH1 = 2'h3;

  // codes: two's complement in, straight binary level out
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
  localparam logic [CODE_W-1:0] SIGN_FLIP = 12'h800;
  localparam logic [CODE_W-1:0] LEVEL_RST = CODE_RST ^ SIGN_FLIP;

  // output termination while powered down
  typedef enum logic [1:0] {
    DDP_TERM_FLOAT = 2'b00,
    DDP_TERM_1K = 2'b01,
    DDP_TERM_100K = 2'b10
  } ddp_term_t;

  // wishbone register map, byte addresses
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] ADR_CMD = 8'h04;
  localparam logic [ADR_W-1:0] ADR_STATUS = 8'h08;
  localparam logic [ADR_W-1:0] ADR_CODE_A = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_CODE_B = 8'h10;
  localparam logic [ADR_W-1:0] ADR_LAST = 8'h14;
  localparam logic [ADR_W-1:0] ADR_FRAMES = 8'h18;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam int CTRL_LINK_EN = 0;
  localparam int TMP_LSB = 16;
  localparam int FRM_W = 8;
  localparam int FRM_IGN_LSB = 8;

endpackage

// ---- sim/ddp_core_monitor.sv ----
// port checker of the converter control core
// bound from the testbench; one clk_sys domain, rst async
`timescale 1ns/1ps
`default_nettype none
module ddp_core_monitor
  import ddp_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // link and clear
  input wire logic frame_sync_n,
  input wire logic async_clear_n,
  // converter side
  input wire logic [ddp_pkg::CODE_W-1:0] level_a,
  input wire logic [ddp_pkg::CODE_W-1:0] level_b,
  input wire logic pd_a,
  input wire logic pd_b,
  input wire ddp_pkg::ddp_term_t term_a,
  input wire ddp_pkg::ddp_term_t term_b,
  input wire logic clear_active
);
  logic fs_q;
  logic [3:0] cnt;
  // distance from the last strobe rise or bus access, saturating
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fs_q <= 1'b1;
      cnt <= 4'hf;
    end else begin
      fs_q <= frame_sync_n;
      // a software command acts in the request cycle, at the same edge that raises ack
      if ((frame_sync_n && !fs_q) || (wb_cyc_i && wb_stb_i)) begin
        cnt <= 4'h0;
      end else if (cnt != 4'hf) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_ack_a: assert property (bus_req |=> ack_pulse)
    else $error("bus ack missing");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved");
  clr_mid_a: assert property (clear_active |-> level_a == LEVEL_RST && !pd_a && !pd_b)
    else $error("clear not midscale");
  clr_flag_a: assert property (!async_clear_n |-> clear_active)
    else $error("clear flag low");
  clr_exit_a: assert property ($fell(clear_active) |-> level_b == LEVEL_RST)
    else $error("level moved in clear");
  lvl_cause_a: assert property (!clear_active && ($changed(level_a) || $changed(pd_b)) |-> cnt <= 4'h7)
    else $error("output changed unprompted");
  term_code_a: assert property (term_a != 2'b11 && term_b != 2'b11)
    else $error("bad term code");
endmodule
`default_nettype wire

// ---- sim/ddp_host.sv ----
// host model writing frames on the serial link
// clock runs only inside frames; data inverted once released
`timescale 1ns/1ps
`default_nettype none
module ddp_host (
  // serial link
  output logic serial_clk,
  output logic frame_sync_n,
  output logic serial_in
);
  initial begin
    serial_clk = 1'b1;
    frame_sync_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    frame_sync_n = 1'b0;
    #20;
    for (int i = 15; i > 15 - n; i--) begin
      serial_in = w[i];
      #15 serial_clk = 1'b0;
      #15 serial_clk = 1'b1;
    end
    // hold covers the word event toggle sync latency
    #500 frame_sync_n = 1'b1;
    serial_in = ~serial_in;
    #400;
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench of the converter control core
// host model drives the link; bus reads checked from a queue
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  import ddp_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, clr_n = 1'b1;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, e, r;
  logic ack, pda, pdb, clra, sclk, fsn, sin;
  logic [CODE_W-1:0] lva, lvb, ea, eb;
  ddp_term_t ta, tb, et;
  logic [31:0] q[$];
  int n_mismatch = 0, checked = 0, seed = 32'h1d57;
  always #50 clk_sys = ~clk_sys;
  ddp_host host_u (.serial_clk(sclk), .frame_sync_n(fsn), .serial_in(sin));
  ddp_core dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_clk(sclk), .frame_sync_n(fsn), .serial_in(sin), .async_clear_n(clr_n),
    .level_a(lva), .level_b(lvb), .pd_a(pda), .pd_b(pdb), .term_a(ta), .term_b(tb),
    .clear_active(clra));
  task automatic final_report;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // reads carry the expected word in d
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (!w) q.push_back(d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic look;
    repeat (4) @(posedge clk_sys);
    `CHK("level_a", ea, lva)
    `CHK("level_b", eb, lvb)
  endtask
  task automatic upd(input logic ch, input logic [CODE_W-1:0] d);
    host_u.send({2'b01, ch, 1'b0, d}, 16);
    if (ch) eb = d ^ SIGN_FLIP;
    else ea = d ^ SIGN_FLIP;
    look();
  endtask
  always @(posedge clk_sys) begin
    if (ack === 1'b1 && we === 1'b0) begin
      e = q.pop_front();
      `CHK("rdata", e, rdat)
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    ea = LEVEL_RST;
    eb = LEVEL_RST;
    repeat (3) @(posedge clk_sys);
    look();
    bus(1'b0, ADR_STATUS, RD_ZERO);
    bus(1'b0, ADR_CTRL, CTRL_RST);
    bus(1'b0, 8'h40, RD_ZERO);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      upd(i[0], (i == 0) ? 12'h800 : (i == 1) ? 12'h7ff : r[11:0]);
    end
    // short frame must leave both channels alone
    host_u.send({4'h4, 12'h123}, 15);
    look();
    bus(1'b1, ADR_CTRL, 32'h0000_0000);
    host_u.send({4'h6, 12'h456}, 16);
    look();
    bus(1'b1, ADR_CTRL, CTRL_RST);
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 4; t++) begin
        r = $random(seed);
        host_u.send({4'hc, r[11:0]}, 16);
        ea = r[11:0] ^ SIGN_FLIP;
        eb = ea;
        look();
        host_u.send({s[1:0], r[13], 1'b1, t[1:0], r[9:0]}, 16);
        repeat (4) @(posedge clk_sys);
        et = (t == 1) ? DDP_TERM_1K : (t == 2) ? DDP_TERM_100K : DDP_TERM_FLOAT;
        `CHK("pd_a", s != 2, pda)
        `CHK("pd_b", s != 1, pdb)
        if (s != 2) `CHK("term_a", et, ta)
        if (s != 1) `CHK("term_b", et, tb)
      end
    end
    bus(1'b0, ADR_STATUS, 32'h0000_0003);
    upd(1'b0, r[11:0]);
    `CHK("pd_a", 1'b0, pda)
    `CHK("pd_b", 1'b1, pdb)
    clr_n <= 1'b0;
    ea = LEVEL_RST;
    eb = LEVEL_RST;
    look();
    `CHK("pd_b", 1'b0, pdb)
    `CHK("clear_active", 1'b1, clra)
    clr_n <= 1'b1;
    look();
    `CHK("clear_active", 1'b0, clra)
    bus(1'b0, ADR_CODE_B, RD_ZERO);
    upd(1'b1, r[11:0]);
    // software command path: all-channel update through the bus
    r = $random(seed);
    bus(1'b1, ADR_CMD, {16'h0000, 4'hc, r[11:0]});
    ea = r[11:0] ^ SIGN_FLIP;
    eb = ea;
    look();
    bus(1'b0, ADR_CODE_A, {4'h0, r[11:0], 4'h0, r[11:0]});
    bus(1'b0, ADR_LAST, {16'h0000, 4'hc, r[11:0]});
    // 38 executed frames, 2 ignored strobe rises (short and dropped)
    bus(1'b0, ADR_FRAMES, 32'h0000_0226);
    final_report();
  end
  initial begin
    #2_000_000;
    n_mismatch++;
    final_report();
  end
endmodule
bind ddp_core ddp_core_monitor mon_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .frame_sync_n(frame_sync_n),
  .async_clear_n(async_clear_n), .level_a(level_a), .level_b(level_b), .pd_a(pd_a),
  .pd_b(pd_b), .term_a(term_a), .term_b(term_b), .clear_active(clear_active));
`default_nettype wire
